// ==== logic/ais_input_select.sv ====
// How it works
// - Setting B negative input is analog input 1 when its bit is 1, else lower reference.
// - Setting B positive codes 0..15 pick external inputs 0..15 in order.
// - Setting A negative input is analog input 1 when set, lower reference when clear.
// - Setting A positive codes map to inputs exactly as setting B codes.
// - Unused bit pairs in channel select ignore writes and read zero.
// - The positive field top bit extends selection to internal references.
// - Analog-disable bit 1 makes the pin digital and grounds its mux input.
// - Analog-disable bit 0 keeps the pin analog and samples its voltage.
// - High config bit 1 at 0 enables the band-gap channel, at 1 disables it.
// - High config bit 0 at 0 enables the half band-gap channel, at 1 disables it.
// - With alternation on, settings A and B alternate from A; otherwise always A.
// - Scan-select bits include channels in setting A scanning; zero bits exclude them.
// - Only setting A scans; setting B keeps its fixed selections.
`timescale 1ns/1ps
`default_nettype none
`include "ais_regs.svh"
module ais_input_select
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic alternate_settings_enable_i,
  input wire logic scan_enable_i,
  input wire logic conv_next_i,
  output ais_pkg::ais_code_t pos_code_o,
  output ais_pkg::ais_word_t pos_pin_sel_o,
  output ais_pkg::ais_word_t pos_pin_gnd_o,
  output logic bandgap_sel_o,
  output logic half_bandgap_sel_o,
  output logic neg_analog_input_1_o,
  output logic setting_b_active_o,
  output logic pos_code_invalid_o,
  output ais_pkg::ais_word_t pin_digital_o,
  output logic bandgap_enable_o,
  output logic half_bandgap_enable_o
);
  import ais_pkg::*;

  ais_word_t chs_r;
  ais_word_t pin_analog_disable_r;
  logic [1:0] pcfgh_r;
  ais_word_t scan_channel_include_r;
  ais_setting_e setting_r;
  logic [3:0] scan_ptr_r;
  logic [3:0] scan_ptr_nxt;
  logic [3:0] scan_first;
  ais_code_t code_nxt;
  logic neg_nxt;
  logic setup;
  logic access;
  logic wr_en;
  logic hit;
  logic [31:0] rd_nxt;
  ais_sel_if sel_if ();

  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_o;
  assign wr_en = access && pwrite_i && !pslverr_o;

  // Next included channel after a start point, cyclic
  function automatic logic [3:0] next_incl(input logic [3:0] from, input logic [15:0] mask);
    logic [3:0] idx;
    logic found;
    idx = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      if (!found && mask[4'(from + 4'(i))])
      begin
        idx = 4'(from + 4'(i));
        found = 1'b1;
      end
    end
    return idx;
  endfunction : next_incl

  // Address decode and read data for the setup cycle
  always_comb
  begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
      `AIS_CHS_OFF: rd_nxt = {16'h0000, chs_r & `AIS_CHS_MASK};
      `AIS_PCFGL_OFF: rd_nxt = {16'h0000, pin_analog_disable_r};
      `AIS_PCFGH_OFF: rd_nxt = {30'h0000_0000, pcfgh_r};
      `AIS_SCAN_CHANNEL_INCLUDE_OFF: rd_nxt = {16'h0000, scan_channel_include_r};
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait APB answer: ready in the first access cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= setup;
      if (setup)
      begin
        pslverr_o <= !hit;
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_nxt;
      end
      else if (access)
      begin
        pslverr_o <= 1'b0;
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // Channel select register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      chs_r <= `AIS_CHS_RST;
    end
    else if (wr_en && paddr_i == `AIS_CHS_OFF)
    begin
      chs_r <= pwdata_i[15:0] & `AIS_CHS_MASK;
    end
  end

  // Pin configuration registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      pin_analog_disable_r <= `AIS_PCFGL_RST;
      pcfgh_r <= `AIS_PCFGH_RST;
    end
    else if (wr_en && paddr_i == `AIS_PCFGL_OFF)
    begin
      pin_analog_disable_r <= pwdata_i[15:0];
    end
    else if (wr_en && paddr_i == `AIS_PCFGH_OFF)
    begin
      pcfgh_r <= pwdata_i[1:0];
    end
  end

  // Scan select register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      scan_channel_include_r <= `AIS_SCAN_CHANNEL_INCLUDE_RST;
    end
    else if (wr_en && paddr_i == `AIS_SCAN_CHANNEL_INCLUDE_OFF)
    begin
      scan_channel_include_r <= pwdata_i[15:0];
    end
  end

  // Setting in use, alternating from A
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      setting_r <= AIS_SET_A;
    end
    else if (!alternate_settings_enable_i)
    begin
      setting_r <= AIS_SET_A;
    end
    else if (conv_next_i)
    begin
      case (setting_r)
        AIS_SET_A: setting_r <= AIS_SET_B;
        AIS_SET_B: setting_r <= AIS_SET_A;
        default: setting_r <= AIS_SET_A;
      endcase
    end
  end

  // Scan pointer walks only included channels, only on setting A
  assign scan_first = next_incl(4'hF, scan_channel_include_r);
  always_comb
  begin
    scan_ptr_nxt = scan_ptr_r;
    if (!scan_enable_i)
    begin
      scan_ptr_nxt = scan_first;
    end
    else if (!scan_channel_include_r[scan_ptr_r])
    begin
      scan_ptr_nxt = next_incl(scan_ptr_r, scan_channel_include_r);
    end
    else if (conv_next_i && setting_r == AIS_SET_A)
    begin
      scan_ptr_nxt = next_incl(scan_ptr_r, scan_channel_include_r);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      scan_ptr_r <= 4'h0;
    end
    else
    begin
      scan_ptr_r <= scan_ptr_nxt;
    end
  end

  // Positive and negative choice for the active setting
  always_comb
  begin
    if (setting_r == AIS_SET_B)
    begin
      code_nxt = chs_r[`AIS_POS_B_MSB:`AIS_POS_B_LSB];
      neg_nxt = chs_r[`AIS_NEG_B_BIT];
    end
    else
    begin
      neg_nxt = chs_r[`AIS_NEG_A_BIT];
      if (scan_enable_i && scan_channel_include_r != 16'h0000)
      begin
        code_nxt = {1'b0, scan_ptr_r};
      end
      else
      begin
        code_nxt = chs_r[`AIS_POS_A_MSB:`AIS_POS_A_LSB];
      end
    end
  end

  assign sel_if.pos_code = code_nxt;
  assign sel_if.pin_digital = pin_analog_disable_r;
  assign sel_if.bg_dis = pcfgh_r[`AIS_BG_DIS_BIT];
  assign sel_if.hbg_dis = pcfgh_r[`AIS_HBG_DIS_BIT];

  ais_mux_sel u_mux_sel
  (
    .sel(sel_if.dec)
  );

  // Registered multiplexer controls
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      pos_code_o <= 5'h00;
      pos_pin_sel_o <= 16'h0000;
      pos_pin_gnd_o <= 16'h0000;
      bandgap_sel_o <= 1'b0;
      half_bandgap_sel_o <= 1'b0;
      neg_analog_input_1_o <= 1'b0;
      setting_b_active_o <= 1'b0;
      pos_code_invalid_o <= 1'b0;
    end
    else
    begin
      pos_code_o <= code_nxt;
      pos_pin_sel_o <= sel_if.pin_sel;
      pos_pin_gnd_o <= sel_if.pin_gnd;
      bandgap_sel_o <= sel_if.bg_sel;
      half_bandgap_sel_o <= sel_if.hbg_sel;
      neg_analog_input_1_o <= neg_nxt;
      setting_b_active_o <= (setting_r == AIS_SET_B);
      pos_code_invalid_o <= sel_if.invalid;
    end
  end

  // Registered pin mode and reference enables
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      pin_digital_o <= 16'h0000;
      bandgap_enable_o <= 1'b0;
      half_bandgap_enable_o <= 1'b0;
    end
    else
    begin
      pin_digital_o <= pin_analog_disable_r;
      bandgap_enable_o <= !pcfgh_r[`AIS_BG_DIS_BIT];
      half_bandgap_enable_o <= !pcfgh_r[`AIS_HBG_DIS_BIT];
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_neg_b_route: assert property ((setting_r == AIS_SET_B && chs_r[15]) |=> neg_analog_input_1_o)
    else $error("setting B negative input not routed to input 1");

  a_neg_a_route: assert property ((setting_r == AIS_SET_A && !chs_r[7]) |=> !neg_analog_input_1_o)
    else $error("setting A negative input not lower reference");

  a_pos_b_code: assert property ((setting_r == AIS_SET_B && chs_r[12:8] == 5'h03 && !pin_analog_disable_r[3])
    |=> pos_pin_sel_o == 16'h0008)
    else $error("setting B code 3 did not select input 3");

  a_pos_a_code: assert property ((setting_r == AIS_SET_A && !scan_enable_i && chs_r[4:0] == 5'h0F
    && !pin_analog_disable_r[15]) |=> pos_pin_sel_o == 16'h8000)
    else $error("setting A code 15 did not select input 15");

  a_rsvd_zero: assert property ((setup && !pwrite_i && paddr_i == `AIS_CHS_OFF)
    |=> prdata_o[14:13] == 2'h0 && prdata_o[6:5] == 2'h0)
    else $error("unused channel select bits read nonzero");

  a_pin_digital: assert property ((wr_en && paddr_i == `AIS_PCFGL_OFF)
    |=> ##1 pin_digital_o == $past(pwdata_i[15:0], 2))
    else $error("pin mode did not follow write");

  a_gnd_tie: assert property ((pos_pin_gnd_o & ~$past(pin_analog_disable_r)) == 16'h0000)
    else $error("analog pin tied to ground");

  a_bg_enable: assert property ((!pcfgh_r[1] && (code_nxt == 5'h10)) |=> bandgap_enable_o
    && bandgap_sel_o)
    else $error("band-gap channel not enabled");

  a_hbg_disable: assert property (pcfgh_r[0] |=> !half_bandgap_sel_o && !half_bandgap_enable_o)
    else $error("half band-gap channel not disabled");

  a_alt_toggle: assert property ((alternate_settings_enable_i && conv_next_i && setting_r == AIS_SET_A)
    |=> setting_r == AIS_SET_B)
    else $error("alternation did not move to setting B");

  a_alt_off: assert property (!alternate_settings_enable_i |=> setting_r == AIS_SET_A)
    else $error("setting A not used without alternation");

  a_scan_incl: assert property ((scan_enable_i && setting_r == AIS_SET_A && conv_next_i
    && scan_channel_include_r != 16'h0000 && $stable(scan_channel_include_r)) |=> ##1 scan_channel_include_r[scan_ptr_r])
    else $error("scan landed on excluded channel");

  a_b_fixed: assert property ((setting_r == AIS_SET_B) |=> pos_code_o == $past(chs_r[12:8]))
    else $error("setting B code not fixed");

  a_reset_clear: assert property (disable iff (1'b0) !rstn_i |=> chs_r == 16'h0000
    && pin_analog_disable_r == 16'h0000 && pcfgh_r == 2'h0 && scan_channel_include_r == 16'h0000)
    else $error("registers not cleared by reset");

  a_bus_ready: assert property (setup |=> pready_o ##1 !pready_o)
    else $error("bus answer not one cycle");

endmodule : ais_input_select
`default_nettype wire

// ==== logic/ais_regs.svh ====
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH

// Register byte offsets
`define AIS_CHS_OFF 12'h000
`define AIS_PCFGL_OFF 12'h004
`define AIS_PCFGH_OFF 12'h008
`define AIS_SCAN_CHANNEL_INCLUDE_OFF 12'h00C

// Reset values
`define AIS_CHS_RST 16'h0000
`define AIS_PCFGL_RST 16'h0000
`define AIS_PCFGH_RST 2'h0
`define AIS_SCAN_CHANNEL_INCLUDE_RST 16'h0000

// Implemented bits of the channel select register
`define AIS_CHS_MASK 16'h9F9F

// Channel select fields
`define AIS_NEG_B_BIT 15
`define AIS_POS_B_MSB 12
`define AIS_POS_B_LSB 8
`define AIS_NEG_A_BIT 7
`define AIS_POS_A_MSB 4
`define AIS_POS_A_LSB 0

// High pin configuration fields
`define AIS_BG_DIS_BIT 1
`define AIS_HBG_DIS_BIT 0

// Extended positive codes for internal sources
`define AIS_CODE_BG 5'h10
`define AIS_CODE_HBG 5'h11

`endif

// ==== logic/ais_pkg.sv ====
`default_nettype none
package ais_pkg;
  typedef enum logic {AIS_SET_A, AIS_SET_B} ais_setting_e;
  typedef logic [4:0] ais_code_t;
  typedef logic [15:0] ais_word_t;
endpackage : ais_pkg
`default_nettype wire

// ==== logic/ais_sel_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ais_sel_if;
  logic [4:0] pos_code;
  logic [15:0] pin_digital;
  logic bg_dis;
  logic hbg_dis;
  logic [15:0] pin_sel;
  logic [15:0] pin_gnd;
  logic bg_sel;
  logic hbg_sel;
  logic invalid;
  modport dec (input pos_code, pin_digital, bg_dis, hbg_dis,
               output pin_sel, pin_gnd, bg_sel, hbg_sel, invalid);
  modport ctl (output pos_code, pin_digital, bg_dis, hbg_dis,
               input pin_sel, pin_gnd, bg_sel, hbg_sel, invalid);
endinterface : ais_sel_if
`default_nettype wire

// ==== logic/ais_mux_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ais_regs.svh"
module ais_mux_sel
(
  ais_sel_if.dec sel
);
  import ais_pkg::*;

  logic [15:0] onehot;
  logic is_ext;

  // Codes 0..15 pick external inputs in order; shared by both settings
  always_comb
  begin
    is_ext = (sel.pos_code[4] == 1'b0);
    onehot = 16'h0000;
    if (is_ext)
    begin
      onehot[sel.pos_code[3:0]] = 1'b1;
    end
  end

  // Digital pins feed analog ground, analog pins are sampled
  assign sel.pin_sel = onehot & ~sel.pin_digital;
  assign sel.pin_gnd = onehot & sel.pin_digital;

  // Extended codes reach the internal references when enabled
  assign sel.bg_sel = (sel.pos_code == `AIS_CODE_BG) && !sel.bg_dis;
  assign sel.hbg_sel = (sel.pos_code == `AIS_CODE_HBG) && !sel.hbg_dis;
  assign sel.invalid = !is_ext && (sel.pos_code != `AIS_CODE_BG)
                       && (sel.pos_code != `AIS_CODE_HBG);
endmodule : ais_mux_sel
`default_nettype wire

// ==== test/ais_mux_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ais_mux_model
#(
  parameter logic [11:0] BG_MV = 12'h258,
  parameter logic [11:0] HBG_MV = 12'h12C
)
(
  input wire ais_pkg::ais_word_t pin_sel_i,
  input wire logic bg_sel_i,
  input wire logic hbg_sel_i,
  input wire logic neg_an1_i,
  output logic [11:0] sample_o
);
  import ais_pkg::*;
  logic [11:0] pos_mv;
  logic [11:0] neg_mv;
  // Sample-and-hold difference, clipped at zero since it is unipolar
  always_comb
  begin
    pos_mv = 12'h000;
    for (int n = 0; n < 16; n++)
      if (pin_sel_i[n]) pos_mv = 12'h064 + 12'h010 * 12'(n);
    if (bg_sel_i) pos_mv = BG_MV;
    if (hbg_sel_i) pos_mv = HBG_MV;
    neg_mv = neg_an1_i ? 12'h074 : 12'h000;
    sample_o = (pos_mv >= neg_mv) ? pos_mv - neg_mv : 12'h000;
  end
endmodule : ais_mux_model
`default_nettype wire

// ==== test/ais_input_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ais_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ais_input_select_tb;
  import ais_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic alt = 1'b0;
  logic scan = 1'b0;
  logic conv = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, neg1, set_b, inval, bg_sel, hbg_sel, bg_en, hbg_en;
  ais_code_t pos_code;
  ais_word_t pin_sel, pin_gnd, pin_dig;
  logic [11:0] sample;
  logic [4:0] ca, cb;
  logic na, nb;
  logic [15:0] chs, pl;
  integer seed = 5;
  integer fails = 0;
  integer check_count = 0;

  ais_input_select dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .alternate_settings_enable_i(alt), .scan_enable_i(scan), .conv_next_i(conv),
    .pos_code_o(pos_code), .pos_pin_sel_o(pin_sel), .pos_pin_gnd_o(pin_gnd),
    .bandgap_sel_o(bg_sel), .half_bandgap_sel_o(hbg_sel), .neg_analog_input_1_o(neg1),
    .setting_b_active_o(set_b), .pos_code_invalid_o(inval), .pin_digital_o(pin_dig),
    .bandgap_enable_o(bg_en), .half_bandgap_enable_o(hbg_en));

  ais_mux_model mux_u (.pin_sel_i(pin_sel), .bg_sel_i(bg_sel), .hbg_sel_i(hbg_sel),
    .neg_an1_i(neg1), .sample_o(sample));

  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : tick

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    tick(2);
  endtask : apb

  task automatic step();
    @(posedge clk_sys_i);
    conv <= 1'b1;
    @(posedge clk_sys_i);
    conv <= 1'b0;
    tick(2);
  endtask : step

  function automatic logic [11:0] mv(input logic [4:0] c);
    return 12'h064 + 12'h010 * {7'h00, c};
  endfunction : mv

  task automatic check_sel(input logic [4:0] c, input logic ng, input logic [1:0] ph);
    logic [15:0] oh;
    logic [11:0] p;
    logic [11:0] q;
    oh = (c < 5'h10) ? (16'h0001 << c) : 16'h0000;
    p = (c < 5'h10 && !pl[c[3:0]]) ? mv(c) : 12'h000;
    if (c == 5'h10 && !ph[1]) p = 12'h258;
    if (c == 5'h11 && !ph[0]) p = 12'h12C;
    q = ng ? mv(5'h01) : 12'h000;
    `CHK(pos_code, c)
    `CHK(pin_sel, oh & ~pl)
    `CHK(pin_gnd, oh & pl)
    `CHK(pin_dig, pl)
    `CHK(neg1, ng)
    `CHK(bg_sel, c == 5'h10 && !ph[1])
    `CHK(hbg_sel, c == 5'h11 && !ph[0])
    `CHK(inval, c > 5'h11)
    `CHK(sample, (p >= q) ? p - q : 12'h000)
  endtask : check_sel

  initial
  begin
    tick(3);
    rstn_i <= 1'b1;
    tick(2);
    `CHK(bg_en, 1'b1)
    `CHK(hbg_en, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1'b1, `AIS_CHS_OFF, 32'hFFFF_FFFF);
    apb(1'b0, `AIS_CHS_OFF, 32'h0000_0000);
    `CHK(rd, 32'h0000_9F9F)
    apb(1'b1, `AIS_PCFGH_OFF, 32'hFFFF_FFFF);
    apb(1'b0, `AIS_PCFGH_OFF, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, `AIS_PCFGH_OFF, 32'h0000_0000);
    for (int k = 0; k < 30; k++)
    begin
      ca = (k == 2) ? 5'h0F : 5'($random(seed)) & 5'h0F;
      cb = (k == 0) ? 5'h0F : (k == 2) ? 5'h03 : 5'($random(seed)) & 5'h0F;
      na = 1'($random(seed));
      nb = 1'($random(seed));
      pl = (k == 1) ? 16'hFFFF : (k == 2) ? 16'h0000 : 16'($random(seed));
      chs = {nb, 2'b00, cb, na, 2'b00, ca};
      apb(1'b1, `AIS_CHS_OFF, {16'h0000, chs});
      apb(1'b1, `AIS_PCFGL_OFF, {16'h0000, pl});
      apb(1'b0, `AIS_CHS_OFF, 32'h0000_0000);
      `CHK(rd, {16'h0000, chs})
      `CHK(err, 1'b0)
      check_sel(ca, na, 2'b00);
      alt <= 1'b1;
      step();
      `CHK(set_b, 1'b1)
      check_sel(cb, nb, 2'b00);
      step();
      `CHK(set_b, 1'b0)
      alt <= 1'b0;
      step();
      `CHK(pos_code, ca)
    end
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `AIS_PCFGH_OFF, 32'(i & 3));
      apb(1'b1, `AIS_CHS_OFF, 32'h10 + 32'(i >> 2));
      check_sel(5'h10 + 5'(i >> 2), 1'b0, 2'(i));
      `CHK(bg_en, ~i[1])
      `CHK(hbg_en, ~i[0])
    end
    apb(1'b1, `AIS_CHS_OFF, 32'h0000_0012);
    `CHK(inval, 1'b1)
    apb(1'b1, `AIS_SCAN_CHANNEL_INCLUDE_OFF, 32'h0000_0024);
    apb(1'b1, `AIS_CHS_OFF, 32'h0000_8B07);
    scan <= 1'b1;
    tick(3);
    `CHK(pos_code, 5'h02)
    step();
    `CHK(pos_code, 5'h05)
    step();
    `CHK(pos_code, 5'h02)
    alt <= 1'b1;
    step();
    `CHK({pos_code, neg1}, 6'h17)
    step();
    `CHK({pos_code, neg1}, 6'h0A)
    alt <= 1'b0;
    scan <= 1'b0;
    rstn_i <= 1'b0;
    tick(2);
    rstn_i <= 1'b1;
    apb(1'b0, `AIS_SCAN_CHANNEL_INCLUDE_OFF, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(pin_dig, 16'h0000)
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    give_verdict();
  end
endmodule : ais_input_select_tb
`default_nettype wire
